// ==== hw/nav_defines.svh ====
// Contract
// - exposure is 16 bits, reset 0x0100
// - exposure auto-adjusted at most once per frame
// - each adjustment moves exposure by one sixteenth, increases clamped at 0xffff
// - grabber takes one pixel per frame, holds it
// - valid grabber read sets bit 7, advances, re-arms
// - full image takes 361 valid grabber reads
// - any grabber write resets to pixel 0
// - first identifier register is a fixed byte
// - second identifier: fixed upper nibble, low reserved
// - status bit 7 flags motion since read
// - status bits 4/3 flag Y/X overflow
// - status low bits give resolution code
// - deltas are signed bytes, cleared on read
`ifndef NAV_DEFINES_SVH
`define NAV_DEFINES_SVH

// register addresses (7-bit)
`define NAV_ADDR_PID       7'h00
`define NAV_ADDR_PID_NIB   7'h01
`define NAV_ADDR_EXP_HI    7'h09
`define NAV_ADDR_EXP_LO    7'h0a
`define NAV_ADDR_GRAB      7'h0b
`define NAV_ADDR_STATUS    7'h16
`define NAV_ADDR_DX        7'h17
`define NAV_ADDR_DY        7'h18

// serial frame: address byte msb set means write
`define NAV_WR_BIT         7

// reset values and field positions
`define NAV_EXP_RST        16'h0100
`define NAV_EXP_STEP_SHIFT 4
`define NAV_ST_MOT         7
`define NAV_ST_Y_OVERFLOW_FLAG        4
`define NAV_ST_X_OVERFLOW_FLAG        3
`define NAV_GRAB_VALID     7
`define NAV_PIX_LAST       9'h168

// exposure control targets (pixel sum over 361 pixels, peak pixel)
`define NAV_SUM_HIGH       16'h70d0
`define NAV_SUM_LOW        16'h3868
`define NAV_MAX_HIGH       7'h7c

`endif

// ==== hw/nav_pkg.sv ====
package nav_pkg;

   typedef enum logic [2:0]
   {
      SP_ADDR  = 3'b001,
      SP_WDATA = 3'b010,
      SP_RDATA = 3'b100
   } nav_sp_state_t;

   typedef enum logic [2:0]
   {
      GR_WAIT_FRAME = 3'b001,
      GR_WAIT_PIX   = 3'b010,
      GR_FULL       = 3'b100
   } nav_grab_state_t;

endpackage : nav_pkg

// ==== hw/nav_fifo.sv ====
module nav_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_idx_q;
   logic [AW-1:0]    rd_idx_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_idx_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] i);
      next_idx = (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
   endfunction : next_idx

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem_q[wr_idx_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_idx_q <= '0;
         rd_idx_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_idx_q <= next_idx(wr_idx_q);
         end
         if (pop)
         begin
            rd_idx_q <= next_idx(rd_idx_q);
         end
         if (push && !pop)
         begin
            count_q <= count_q + 1'b1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : nav_fifo

// ==== hw/nav_status_regs.sv ====
`include "nav_defines.svh"

module nav_status_regs
   import nav_pkg::*;
#(
   parameter logic [7:0] PART_ID     = 8'h5a, // arbitrary value
   parameter logic [3:0] PART_NIBBLE = 4'h3,  // arbitrary value
   parameter int         FIFO_DEPTH  = 8
)
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // two-wire serial port
   input  wire logic        sclk,
   input  wire logic        sdio_i,
   output logic             sdio_o,
   output logic             sdio_oe,
   // pixel stream from image acquisition
   input  wire logic        pix_valid,
   output logic             pix_ready,
   input  wire logic        pix_first,
   input  wire logic [6:0]  pixel_value,
   // motion from the navigation engine
   input  wire logic        mot_valid,
   input  wire logic [7:0]  mot_dx,
   input  wire logic [7:0]  mot_dy,
   // configuration and state out
   input  wire logic [1:0]  resolution_code,
   output logic [15:0]      exposure_value
);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // saturating signed byte add, msb of result flags overflow
   function automatic logic [8:0] sat_add8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7])
      begin
         sat_add8 = {1'b1, (s[8] ? 8'h80 : 8'h7f)};
      end
      else
      begin
         sat_add8 = {1'b0, s[7:0]};
      end
   endfunction : sat_add8

   // serial port
   nav_sp_state_t   sp_state_q;
   logic            sclk_q;
   logic [2:0]      bit_cnt_q;
   logic [7:0]      sh_q;
   logic [6:0]      addr_q;
   logic [7:0]      out_sh_q;
   logic            sclk_rise;
   logic            sclk_fall;
   logic [7:0]      addr_word;
   logic            rd_evt;
   logic [6:0]      rd_addr;
   logic            wr_evt;
   logic [7:0]      wr_data;
   logic [7:0]      rd_data;

   assign sclk_rise = sclk && !sclk_q;
   assign sclk_fall = !sclk && sclk_q;
   assign addr_word = {sh_q[6:0], sdio_i};
   assign rd_evt    = (sp_state_q == SP_ADDR) && sclk_rise && (bit_cnt_q == 3'h7)
                      && !addr_word[`NAV_WR_BIT];
   assign rd_addr   = addr_word[6:0];
   assign wr_evt    = (sp_state_q == SP_WDATA) && sclk_rise && (bit_cnt_q == 3'h7);
   assign wr_data   = {sh_q[6:0], sdio_i};

   // device samples on rising sclk, drives read data after falling sclk
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sclk_q     <= 1'b0;
         sp_state_q <= SP_ADDR;
         bit_cnt_q  <= 3'h0;
         sh_q       <= 8'h00;
         addr_q     <= 7'h00;
         out_sh_q   <= 8'h00;
         sdio_o     <= 1'b0;
         sdio_oe    <= 1'b0;
      end
      else
      begin
         sclk_q <= sclk;
         unique case (sp_state_q)
            SP_ADDR:
            begin
               if (sclk_rise)
               begin
                  sh_q      <= addr_word;
                  bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
                  if (bit_cnt_q == 3'h7)
                  begin
                     addr_q <= addr_word[6:0];
                     if (addr_word[`NAV_WR_BIT])
                     begin
                        sp_state_q <= SP_WDATA;
                     end
                     else
                     begin
                        out_sh_q   <= rd_data;
                        sp_state_q <= SP_RDATA;
                     end
                  end
               end
            end
            SP_WDATA:
            begin
               if (sclk_rise)
               begin
                  sh_q      <= wr_data;
                  bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
                  if (bit_cnt_q == 3'h7)
                  begin
                     sp_state_q <= SP_ADDR;
                  end
               end
            end
            SP_RDATA:
            begin
               if (sclk_fall)
               begin
                  sdio_o   <= out_sh_q[7];
                  out_sh_q <= {out_sh_q[6:0], 1'b0};
                  sdio_oe  <= 1'b1;
               end
               else if (sclk_rise)
               begin
                  bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
                  if (bit_cnt_q == 3'h7)
                  begin
                     sdio_oe    <= 1'b0;
                     sp_state_q <= SP_ADDR;
                  end
               end
            end
         endcase
      end
   end

   // pixel path: the fifo is stalled on cycles that touch the grabber,
   // so a capture never races a host read or write of it
   logic [7:0]      f_data;
   logic            f_valid;
   logic            f_ready;
   logic            grab_touch;
   logic            fire;
   logic            f_first;
   logic [6:0]      f_pix;
   logic [8:0]      f_idx;
   logic [8:0]      pix_cnt_q;
   logic [15:0]     sum_q;
   logic [6:0]      max_q;
   logic [15:0]     sum_next;
   logic [6:0]      max_next;
   logic            frame_end;

   assign grab_touch = (rd_evt && rd_addr == `NAV_ADDR_GRAB)
                       || (wr_evt && addr_q == `NAV_ADDR_GRAB);
   assign f_ready    = !grab_touch;
   assign fire       = f_valid && f_ready;
   assign f_first    = f_data[7];
   assign f_pix      = f_data[6:0];
   assign f_idx      = f_first ? 9'h000 : pix_cnt_q;
   assign sum_next   = (f_first ? 16'h0000 : sum_q) + {9'h000, f_pix};
   assign max_next   = (!f_first && max_q > f_pix) ? max_q : f_pix;
   assign frame_end  = fire && (f_idx == `NAV_PIX_LAST);

   nav_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({pix_first, pixel_value}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pix_cnt_q <= 9'h000;
         sum_q     <= 16'h0000;
         max_q     <= 7'h00;
      end
      else if (fire)
      begin
         pix_cnt_q <= 9'(f_idx + 1'b1);
         sum_q     <= sum_next;
         max_q     <= max_next;
      end
   end

   // exposure; a value below 16 has a zero step and stays put
   logic [15:0]     exp_q;
   logic [15:0]     exp_step;
   logic [16:0]     exp_up;
   logic [7:0]      exp_lo_snap_q;

   assign exp_step       = exp_q >> `NAV_EXP_STEP_SHIFT;
   assign exp_up         = {1'b0, exp_q} + {1'b0, exp_step};
   assign exposure_value = exp_q;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         exp_q <= `NAV_EXP_RST;
      end
      else if (frame_end)
      begin
         if (max_next > `NAV_MAX_HIGH || sum_next > `NAV_SUM_HIGH)
         begin
            exp_q <= exp_q - exp_step;
         end
         else if (sum_next < `NAV_SUM_LOW)
         begin
            exp_q <= exp_up[16] ? 16'hffff : exp_up[15:0];
         end
      end
   end

   // low byte frozen at the high-byte read so the pair never tears
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         exp_lo_snap_q <= 8'h00;
      end
      else if (rd_evt && rd_addr == `NAV_ADDR_EXP_HI)
      begin
         exp_lo_snap_q <= exp_q[7:0];
      end
   end

   // pixel grabber
   nav_grab_state_t grab_state_q;
   logic [8:0]      grab_idx_q;
   logic [6:0]      grab_pix_q;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         grab_state_q <= GR_WAIT_FRAME;
         grab_idx_q   <= 9'h000;
         grab_pix_q   <= 7'h00;
      end
      else if (wr_evt && addr_q == `NAV_ADDR_GRAB)
      begin
         grab_idx_q   <= 9'h000;
         grab_state_q <= GR_WAIT_FRAME;
      end
      else if (rd_evt && rd_addr == `NAV_ADDR_GRAB && grab_state_q == GR_FULL)
      begin
         grab_idx_q   <= (grab_idx_q == `NAV_PIX_LAST) ? 9'h000 : 9'(grab_idx_q + 1'b1);
         grab_state_q <= GR_WAIT_FRAME;
      end
      else if (fire)
      begin
         unique case (grab_state_q)
            GR_WAIT_FRAME:
            begin
               if (f_first && grab_idx_q == 9'h000)
               begin
                  grab_pix_q   <= f_pix;
                  grab_state_q <= GR_FULL;
               end
               else if (f_first)
               begin
                  grab_state_q <= GR_WAIT_PIX;
               end
            end
            GR_WAIT_PIX:
            begin
               if (f_idx == grab_idx_q)
               begin
                  grab_pix_q   <= f_pix;
                  grab_state_q <= GR_FULL;
               end
            end
            GR_FULL:
            begin
               grab_pix_q <= grab_pix_q;
            end
         endcase
      end
   end

   // motion accumulation
   logic [7:0]      dx_q;
   logic [7:0]      dy_q;
   logic            motion_flag_q;
   logic            x_overflow_flag_q;
   logic            y_overflow_flag_q;
   logic            clr_x;
   logic            clr_y;
   logic [8:0]      add_x;
   logic [8:0]      add_y;
   logic            mot_nz;

   assign clr_x  = rd_evt && rd_addr == `NAV_ADDR_DX;
   assign clr_y  = rd_evt && rd_addr == `NAV_ADDR_DY;
   assign add_x  = sat_add8(clr_x ? 8'h00 : dx_q, mot_dx);
   assign add_y  = sat_add8(clr_y ? 8'h00 : dy_q, mot_dy);
   assign mot_nz = mot_valid && (mot_dx != 8'h00 || mot_dy != 8'h00);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         dx_q <= 8'h00;
         dy_q <= 8'h00;
      end
      // clear on read, new motion kept
      else
      begin
         dx_q <= mot_valid ? add_x[7:0] : (clr_x ? 8'h00 : dx_q);
         dy_q <= mot_valid ? add_y[7:0] : (clr_y ? 8'h00 : dy_q);
      end
   end

   // flags clear when Y, the last of the pair, is read; a new event wins
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         motion_flag_q     <= 1'b0;
         x_overflow_flag_q <= 1'b0;
         y_overflow_flag_q <= 1'b0;
      end
      else
      begin
         motion_flag_q     <= mot_nz || (motion_flag_q && !clr_y);
         x_overflow_flag_q <= (mot_valid && add_x[8]) || (x_overflow_flag_q && !clr_y);
         y_overflow_flag_q <= (mot_valid && add_y[8]) || (y_overflow_flag_q && !clr_y);
      end
   end

   // read data mux; unmapped addresses read zero
   always_comb
   begin
      rd_data = 8'h00;
      case (rd_addr)
         `NAV_ADDR_PID:     rd_data = PART_ID;
         `NAV_ADDR_PID_NIB: rd_data = {PART_NIBBLE, 4'h0};
         `NAV_ADDR_EXP_HI:  rd_data = exp_q[15:8];
         `NAV_ADDR_EXP_LO:  rd_data = exp_lo_snap_q;
         `NAV_ADDR_GRAB:    rd_data = {grab_state_q == GR_FULL, grab_pix_q};
         `NAV_ADDR_STATUS:  rd_data = {motion_flag_q, 2'b00, y_overflow_flag_q,
                                       x_overflow_flag_q, 1'b0, resolution_code};
         `NAV_ADDR_DX:      rd_data = dx_q;
         `NAV_ADDR_DY:      rd_data = dy_q;
         default:           rd_data = 8'h00;
      endcase
   end

   // checks
   sequence s_grab_take;
      rd_evt && rd_addr == `NAV_ADDR_GRAB && grab_state_q == GR_FULL;
   endsequence

   sequence s_grab_rearm(logic [8:0] idx);
      grab_state_q == GR_WAIT_FRAME
      && grab_idx_q == ((idx == `NAV_PIX_LAST) ? 9'h000 : 9'(idx + 1'b1));
   endsequence

   property p_grab_read;
      logic [8:0] idx;
      (s_grab_take, idx = grab_idx_q) |-> rd_data[`NAV_GRAB_VALID] ##1 s_grab_rearm(idx);
   endproperty
   a_grab_read: assert property (p_grab_read) else $error("grabber read did not advance");

   property p_grab_hold;
      grab_state_q == GR_FULL && !grab_touch |=> grab_state_q == GR_FULL && $stable(grab_pix_q);
   endproperty
   a_grab_hold: assert property (p_grab_hold) else $error("grabbed pixel not held");

   property p_grab_range;
      grab_idx_q <= `NAV_PIX_LAST;
   endproperty
   a_grab_range: assert property (p_grab_range) else $error("grab index out of range");

   property p_grab_write;
      wr_evt && addr_q == `NAV_ADDR_GRAB |=> grab_idx_q == 9'h000 && grab_state_q == GR_WAIT_FRAME;
   endproperty
   a_grab_write: assert property (p_grab_write) else $error("grabber write did not reset");

   property p_exp_hold;
      !frame_end |=> $stable(exp_q);
   endproperty
   a_exp_hold: assert property (p_exp_hold) else $error("exposure moved outside frame end");

   property p_exp_dec;
      frame_end && max_next > `NAV_MAX_HIGH |=> exp_q == $past(exp_q) - ($past(exp_q) >> 4);
   endproperty
   a_exp_dec: assert property (p_exp_dec) else $error("exposure step wrong");

   property p_pid;
      rd_evt && (rd_addr == `NAV_ADDR_PID || rd_addr == `NAV_ADDR_PID_NIB)
      |-> rd_data == ((rd_addr == `NAV_ADDR_PID) ? PART_ID : {PART_NIBBLE, 4'h0});
   endproperty
   a_pid: assert property (p_pid) else $error("identifier value wrong");

   property p_motion_set;
      mot_nz |=> motion_flag_q;
   endproperty
   a_motion_set: assert property (p_motion_set) else $error("motion flag not set");

   property p_flags_clear;
      clr_y && !mot_valid |=> !motion_flag_q && !x_overflow_flag_q && !y_overflow_flag_q
                              && dy_q == 8'h00;
   endproperty
   a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

   property p_dx_clear;
      clr_x && !mot_valid |=> dx_q == 8'h00;
   endproperty
   a_dx_clear: assert property (p_dx_clear) else $error("x delta not cleared");

   property p_status;
      rd_evt && rd_addr == `NAV_ADDR_STATUS
      |-> rd_data[1:0] == resolution_code && rd_data[`NAV_ST_Y_OVERFLOW_FLAG] == y_overflow_flag_q
          && rd_data[`NAV_ST_X_OVERFLOW_FLAG] == x_overflow_flag_q && rd_data[`NAV_ST_MOT] == motion_flag_q;
   endproperty
   a_status: assert property (p_status) else $error("status layout wrong");

endmodule : nav_status_regs

// ==== verification/nav_host_model.sv ====
module nav_host_model
(
   // clock
   input  wire logic sys_clk,
   // serial line
   output logic      sclk,
   output logic      sdio_drv,
   input  wire logic sdio_line
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 4;

   initial
   begin
      sclk     = 1'b0;
      sdio_drv = 1'b0;
   end

   task automatic phase();
      repeat (HALF) @(posedge sys_clk);
      #1;
   endtask : phase

   task automatic send_bit(input logic b);
      sclk     = 1'b0;
      sdio_drv = b;
      phase();
      sclk = 1'b1;
      phase();
   endtask : send_bit

   // one whole frame, msb first; sclk stands low between frames
   task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      rdata = 8'h00;
      send_bit(wr);
      for (int i = 6; i >= 0; i--) send_bit(addr[i]);
      for (int i = 7; i >= 0; i--)
      begin
         if (wr)
         begin
            send_bit(wdata[i]);
         end
         else
         begin
            // released line: keep toggling so a stale value never looks right
            sclk     = 1'b0;
            sdio_drv = ~sdio_drv;
            phase();
            sclk     = 1'b1;
            rdata[i] = sdio_line;
            phase();
         end
      end
      sclk     = 1'b0;
      sdio_drv = ~sdio_drv;
      phase();
   endtask : xfer
endmodule : nav_host_model

// ==== verification/testbench.sv ====
`include "nav_defines.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [7:0] ID_BYTE = 8'ha5; // arbitrary value
   localparam logic [3:0] ID_NIB  = 4'h6;  // arbitrary value

   logic        sys_clk, rst, sclk, sdio_o, sdio_oe, sdio_drv, sdio_line;
   logic        pix_valid, pix_ready, pix_first, mot_valid;
   logic [6:0]  pixel_value;
   logic [7:0]  mot_dx, mot_dy;
   logic [1:0]  resolution_code;
   logic [15:0] exposure_value, exp_model;
   int          n_fail, total_checks;

   assign sdio_line = sdio_oe ? sdio_o : sdio_drv;

   nav_status_regs #(.PART_ID(ID_BYTE), .PART_NIBBLE(ID_NIB), .FIFO_DEPTH(8)) dut
   (
      .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .sdio_i(sdio_line), .sdio_o(sdio_o),
      .sdio_oe(sdio_oe), .pix_valid(pix_valid), .pix_ready(pix_ready),
      .pix_first(pix_first), .pixel_value(pixel_value), .mot_valid(mot_valid),
      .mot_dx(mot_dx), .mot_dy(mot_dy), .resolution_code(resolution_code),
      .exposure_value(exposure_value)
   );

   nav_host_model host
   (
      .sys_clk(sys_clk), .sclk(sclk), .sdio_drv(sdio_drv), .sdio_line(sdio_line)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic rd(input string what, input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.xfer(1'b0, a, 8'h00, d);
      check(what, {8'h00, d}, {8'h00, exp});
   endtask : rd

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host.xfer(1'b1, a, d, unused);
   endtask : wr

   task automatic motion_flag(input logic [7:0] dx, input logic [7:0] dy);
      mot_valid = 1'b1;
      mot_dx    = dx;
      mot_dy    = dy;
      @(posedge sys_clk);
      #1;
      mot_valid = 1'b0;
      // let one idle edge pass so back-to-back calls give two distinct pulses
      @(posedge sys_clk);
      #1;
   endtask : motion_flag

   // bright frames trip the peak limit, dark ones sit under the low sum
   task automatic feed(input logic bright);
      for (int i = 0; i < 361; i++)
      begin
         pix_valid   = 1'b1;
         pix_first   = (i == 0);
         pixel_value = bright ? (7'(i) | 7'h40) : 7'h0a;
         while (pix_ready !== 1'b1)
         begin
            @(posedge sys_clk);
            #1;
         end
         @(posedge sys_clk);
         #1;
      end
      pix_valid = 1'b0;
      pix_first = 1'b0;
      exp_model = bright ? exp_model - (exp_model >> 4) : exp_model + (exp_model >> 4);
      for (int k = 0; k < 60 && exposure_value !== exp_model; k++)
      begin
         @(posedge sys_clk);
         #1;
      end
      check("exposure", exposure_value, exp_model);
   endtask : feed

   task automatic t_reset();
      check("pix_ready", {15'h0000, pix_ready}, 16'h0001);
      check("exposure reset", exposure_value, 16'h0100);
      rd("exp high", `NAV_ADDR_EXP_HI, 8'h01);
      rd("exp low", `NAV_ADDR_EXP_LO, 8'h00);
      rd("part id", `NAV_ADDR_PID, ID_BYTE);
      rd("part nibble", `NAV_ADDR_PID_NIB, {ID_NIB, 4'h0});
      rd("unmapped", 7'h30, 8'h00);
      wr(`NAV_ADDR_EXP_HI, 8'hff);
      rd("read only", `NAV_ADDR_EXP_HI, 8'h01);
      for (int r = 0; r < 4; r++)
      begin
         resolution_code = 2'(r);
         rd("resolution", `NAV_ADDR_STATUS, {6'h00, 2'(r)});
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_motion();
      motion_flag(8'h05, 8'hfd);
      rd("status mot", `NAV_ADDR_STATUS, 8'h83);
      rd("dx", `NAV_ADDR_DX, 8'h05);
      rd("dy", `NAV_ADDR_DY, 8'hfd);
      rd("status idle", `NAV_ADDR_STATUS, 8'h03);
      rd("dx cleared", `NAV_ADDR_DX, 8'h00);
      $display("test motion done");
   endtask : t_motion

   task automatic t_overflow();
      motion_flag(8'h64, 8'h9c);
      motion_flag(8'h64, 8'h9c);
      rd("status ovf", `NAV_ADDR_STATUS, 8'h9b);
      rd("dx sat", `NAV_ADDR_DX, 8'h7f);
      rd("dy sat", `NAV_ADDR_DY, 8'h80);
      rd("status clr", `NAV_ADDR_STATUS, 8'h03);
      $display("test overflow done");
   endtask : t_overflow

   task automatic t_grab();
      exp_model = 16'h0100;
      wr(`NAV_ADDR_GRAB, 8'h00);
      rd("grab empty", `NAV_ADDR_GRAB, 8'h00);
      feed(1'b1);
      rd("grab pix0", `NAV_ADDR_GRAB, 8'hc0);
      rd("grab rearmed", `NAV_ADDR_GRAB, 8'h40);
      feed(1'b1);
      rd("grab pix1", `NAV_ADDR_GRAB, 8'hc1);
      feed(1'b0);
      rd("grab pix2", `NAV_ADDR_GRAB, 8'h8a);
      wr(`NAV_ADDR_GRAB, 8'h5c);
      feed(1'b1);
      rd("grab restart", `NAV_ADDR_GRAB, 8'hc0);
      rd("exp high", `NAV_ADDR_EXP_HI, exp_model[15:8]);
      rd("exp low", `NAV_ADDR_EXP_LO, exp_model[7:0]);
      $display("test grabber done");
   endtask : t_grab

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      $display("watchdog expired");
      summarize();
   end

   initial
   begin
      n_fail          = 0;
      total_checks    = 0;
      rst             = 1'b1;
      pix_valid       = 1'b0;
      pix_first       = 1'b0;
      pixel_value     = 7'h00;
      mot_valid       = 1'b0;
      mot_dx          = 8'h00;
      mot_dy          = 8'h00;
      resolution_code = 2'h0;
      exp_model       = 16'h0100;
      repeat (8) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_motion();
      t_overflow();
      t_grab();
      summarize();
   end
endmodule : testbench
